// File: core/arec_config.sv
// reference, filter, excitation and ready-routing configuration registers
// assumes a command decoder delivering one-cycle read/write strobes with a register index,
// and start/sleep command pulses; all inputs synchronous to core_clk

// Function
// - top two bits of first register pick the conversion reference source
// - two-bit filter field picks none, both, 50 Hz or 60 Hz rejection
// - switch control cleared keeps low-side switch open always
// - switch control set: start opens switch, sleep closes it
// - current field sets common magnitude; 000 off, 001 reserved, 50 to 1500 uA
// - upper routing field connects first source to one of six pins
// - middle routing field connects second source with same encoding
// - ready mode cleared: dedicated pin only; set: shared serial pin too
// - both registers load zero at reset
// - mode field: normal or duty-cycle; rate code 000 is the slowest
module arec_config (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [arec_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [arec_pkg::DATA_W-1:0] reg_wdata,
  output logic [arec_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic start_cmd,
  input wire logic sleep_cmd,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] sample_rate_code,
  input wire logic data_ready,
  input wire logic serial_busy,
  input wire logic serial_dout,
  output logic ref_internal,
  output logic ref_dedicated,
  output logic ref_shared,
  output logic ref_supply,
  output logic reject_50hz,
  output logic reject_60hz,
  output logic filter_rate_mismatch,
  output logic low_side_switch_closed,
  output logic current_enable,
  output logic [arec_pkg::CUR_UA_W-1:0] current_level_ua,
  output logic current_code_reserved,
  output logic [arec_pkg::ROUTE_PINS-1:0] first_source_pins,
  output logic first_route_reserved,
  output logic [arec_pkg::ROUTE_PINS-1:0] second_source_pins,
  output logic second_route_reserved,
  output logic ready_pin_n,
  output logic serial_out_ready_pin
);
  import arec_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ref_cfg;
    logic [DATA_W-1:0] route_cfg;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [REF_KINDS-1:0] ref_onehot;
    logic rej_50;
    logic rej_60;
    logic rate_mismatch;
    logic cur_en;
    logic [CUR_UA_W-1:0] cur_ua;
    logic cur_rsv;
    logic [ROUTE_PINS-1:0] first_pins;
    logic first_rsv;
    logic [ROUTE_PINS-1:0] second_pins;
    logic second_rsv;
    logic ready_n;
    logic dout_pin;
  } arec_cfg_state_s;

  // reset reference selection follows the reset value of the select field
  localparam logic [REF_KINDS-1:0] REF_ONEHOT_RESET =
    REF_KINDS'(1) << REF_FILT_EXC_RESET[REF_SEL_HI:REF_SEL_LO];

  localparam arec_cfg_state_s RESET_STATE = '{
    ref_cfg: REF_FILT_EXC_RESET,
    route_cfg: ROUTE_READY_RESET,
    rdata: READ_UNMAPPED,
    rvalid: 1'b0,
    ref_onehot: REF_ONEHOT_RESET,
    rej_50: 1'b0,
    rej_60: 1'b0,
    rate_mismatch: 1'b0,
    cur_en: 1'b0,
    cur_ua: '0,
    cur_rsv: 1'b0,
    first_pins: '0,
    first_rsv: 1'b0,
    second_pins: '0,
    second_rsv: 1'b0,
    ready_n: 1'b1,
    dout_pin: 1'b1
  };

  arec_cfg_state_s st;
  arec_cfg_state_s next_st;

  // field views of the values about to be registered
  arec_ref_e ref_sel;
  arec_filt_e filt_sel;
  logic [2:0] cur_code;
  logic [2:0] route1_code;
  logic [2:0] route2_code;
  logic ready_on_dout;
  logic slowest_rate;

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;

    // read samples the value held before a same-cycle write
    if (reg_rd)
    begin
      next_st.rvalid = 1'b1;
      case (reg_addr)
        REF_FILT_EXC_ADDR:
        begin
          next_st.rdata = st.ref_cfg;
        end
        ROUTE_READY_ADDR:
        begin
          next_st.rdata = st.route_cfg;
        end
        default:
        begin
          // indices 0 and 1 belong to other register blocks
          next_st.rdata = READ_UNMAPPED;
        end
      endcase
    end

    // whole byte stored as written, reserved codes and the spare bit included
    if (reg_wr)
    begin
      case (reg_addr)
        REF_FILT_EXC_ADDR:
        begin
          next_st.ref_cfg = reg_wdata;
        end
        ROUTE_READY_ADDR:
        begin
          next_st.route_cfg = reg_wdata;
        end
        default:
        begin
          // writes to other indices leave both registers untouched
          next_st.ref_cfg = st.ref_cfg;
        end
      endcase
    end

    ref_sel = arec_ref_e'(next_st.ref_cfg[REF_SEL_HI:REF_SEL_LO]);
    filt_sel = arec_filt_e'(next_st.ref_cfg[FILT_HI:FILT_LO]);
    cur_code = next_st.ref_cfg[CUR_HI:CUR_LO];
    route1_code = next_st.route_cfg[ROUTE1_HI:ROUTE1_LO];
    route2_code = next_st.route_cfg[ROUTE2_HI:ROUTE2_LO];
    ready_on_dout = next_st.route_cfg[READY_MODE_BIT];

    // reference source, one-hot
    next_st.ref_onehot = '0;
    unique case (ref_sel)
      AREC_REF_INTERNAL:
      begin
        next_st.ref_onehot[AREC_REF_INTERNAL] = 1'b1;
      end
      AREC_REF_DEDICATED:
      begin
        next_st.ref_onehot[AREC_REF_DEDICATED] = 1'b1;
      end
      AREC_REF_SHARED:
      begin
        next_st.ref_onehot[AREC_REF_SHARED] = 1'b1;
      end
      AREC_REF_SUPPLY:
      begin
        next_st.ref_onehot[AREC_REF_SUPPLY] = 1'b1;
      end
    endcase

    // mains rejection selection
    unique case (filt_sel)
      AREC_FILT_NONE:
      begin
        next_st.rej_50 = 1'b0;
        next_st.rej_60 = 1'b0;
      end
      AREC_FILT_BOTH:
      begin
        next_st.rej_50 = 1'b1;
        next_st.rej_60 = 1'b1;
      end
      AREC_FILT_50:
      begin
        next_st.rej_50 = 1'b1;
        next_st.rej_60 = 1'b0;
      end
      AREC_FILT_60:
      begin
        next_st.rej_50 = 1'b0;
        next_st.rej_60 = 1'b1;
      end
    endcase

    // the filter is only meaningful at the slowest normal or duty-cycle rate;
    // the device still applies the field, it only flags the host's misuse
    unique case (op_mode)
      MODE_NORMAL, MODE_DUTY:
      begin
        slowest_rate = (sample_rate_code == RATE_SLOWEST);
      end
      default:
      begin
        slowest_rate = 1'b0;
      end
    endcase
    if (filt_sel != AREC_FILT_NONE)
    begin
      next_st.rate_mismatch = !slowest_rate;
    end
    else
    begin
      next_st.rate_mismatch = 1'b0;
    end

    // excitation magnitude, shared by both sources
    next_st.cur_ua = CUR_UA_TABLE[cur_code];
    next_st.cur_rsv = (cur_code == CUR_RESERVED);
    // reserved code drives nothing rather than guessing a magnitude
    if ((cur_code == CUR_OFF) || (cur_code == CUR_RESERVED))
    begin
      next_st.cur_en = 1'b0;
    end
    else
    begin
      next_st.cur_en = 1'b1;
    end

    // source routing; a source with no current behind it stays disconnected
    next_st.first_rsv = (route1_code == ROUTE_RESERVED);
    next_st.second_rsv = (route2_code == ROUTE_RESERVED);
    if (next_st.cur_en)
    begin
      next_st.first_pins = arec_route_onehot(route1_code);
      next_st.second_pins = arec_route_onehot(route2_code);
    end
    else
    begin
      next_st.first_pins = '0;
      next_st.second_pins = '0;
    end

    // ready indication; shared pin carries ready only while no data is shifted out
    next_st.ready_n = !data_ready;
    if (ready_on_dout && !serial_busy)
    begin
      next_st.dout_pin = !data_ready;
    end
    else
    begin
      next_st.dout_pin = serial_dout;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st <= RESET_STATE;
    end
    else
    begin
      st <= next_st;
    end
  end

  arec_low_switch u_low_switch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .low_side_switch_ctrl(st.ref_cfg[SWITCH_BIT]),
    .start_cmd(start_cmd),
    .sleep_cmd(sleep_cmd),
    .switch_closed(low_side_switch_closed)
  );

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign ref_internal = st.ref_onehot[AREC_REF_INTERNAL];
  assign ref_dedicated = st.ref_onehot[AREC_REF_DEDICATED];
  assign ref_shared = st.ref_onehot[AREC_REF_SHARED];
  assign ref_supply = st.ref_onehot[AREC_REF_SUPPLY];
  assign reject_50hz = st.rej_50;
  assign reject_60hz = st.rej_60;
  assign filter_rate_mismatch = st.rate_mismatch;
  assign current_enable = st.cur_en;
  assign current_level_ua = st.cur_ua;
  assign current_code_reserved = st.cur_rsv;
  assign first_source_pins = st.first_pins;
  assign first_route_reserved = st.first_rsv;
  assign second_source_pins = st.second_pins;
  assign second_route_reserved = st.second_rsv;
  assign ready_pin_n = st.ready_n;
  assign serial_out_ready_pin = st.dout_pin;

endmodule

// File: core/arec_low_switch.sv
// low-side switch state between shared_ref_neg_input and analog_ground
// assumes start_cmd and sleep_cmd are one-cycle pulses from the command decoder
module arec_low_switch (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic low_side_switch_ctrl,
  input wire logic start_cmd,
  input wire logic sleep_cmd,
  output logic switch_closed
);
  import arec_pkg::*;

  typedef struct packed {
    logic closed;
  } arec_sw_state_s;

  arec_sw_state_s st;
  arec_sw_state_s next_st;

  always_comb
  begin
    next_st = st;
    if (!low_side_switch_ctrl)
    begin
      next_st.closed = 1'b0;
    end
    else if (start_cmd)
    begin
      // open wins when both commands coincide: safe side for the sensor
      next_st.closed = 1'b0;
    end
    else if (sleep_cmd)
    begin
      next_st.closed = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st <= '{closed: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign switch_closed = st.closed;

endmodule

// File: dv/adc_reference_excitation_config_test.sv
// self-checking bench for arec_config with a host model on the strobe port
// assumes the checker is bound in; 50 ns clock
module adc_reference_excitation_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  import arec_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_wr, reg_rd, reg_rvalid, start_cmd = 0, sleep_cmd = 0;
  logic [1:0] reg_addr, op_mode = 0;
  logic [7:0] reg_wdata, reg_rdata, s, d, mreg [4];
  logic [2:0] sample_rate_code = 0;
  logic data_ready = 0, serial_busy = 0, serial_dout = 0, dr_q = 0, live = 0;
  logic [2:0] pq = 0;
  logic ref_internal, ref_dedicated, ref_shared, ref_supply, reject_50hz, reject_60hz;
  logic filter_rate_mismatch, low_side_switch_closed, current_enable, current_code_reserved;
  logic first_route_reserved, second_route_reserved, ready_pin_n, serial_out_ready_pin;
  logic [10:0] current_level_ua;
  logic [5:0] first_source_pins, second_source_pins;
  integer errors = 0, n_checks = 0, seed = 97;
  int ua [8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
  int fx [4] = '{0, 3, 1, 2};
  always #25 core_clk = ~core_clk;
  arec_host_model host (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .op_mode(op_mode),
    .sample_rate_code(sample_rate_code), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );
  arec_config dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .start_cmd(start_cmd), .sleep_cmd(sleep_cmd), .op_mode(op_mode),
    .sample_rate_code(sample_rate_code), .data_ready(data_ready), .serial_busy(serial_busy),
    .serial_dout(serial_dout), .ref_internal(ref_internal), .ref_dedicated(ref_dedicated),
    .ref_shared(ref_shared), .ref_supply(ref_supply), .reject_50hz(reject_50hz),
    .reject_60hz(reject_60hz), .filter_rate_mismatch(filter_rate_mismatch),
    .low_side_switch_closed(low_side_switch_closed), .current_enable(current_enable),
    .current_level_ua(current_level_ua), .current_code_reserved(current_code_reserved),
    .first_source_pins(first_source_pins), .first_route_reserved(first_route_reserved),
    .second_source_pins(second_source_pins), .second_route_reserved(second_route_reserved),
    .ready_pin_n(ready_pin_n), .serial_out_ready_pin(serial_out_ready_pin)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [6:0] pins(input logic [2:0] r, input logic [2:0] c);
    return {r == 3'h7, (c > 3'h1 && r != 3'h0 && r != 3'h7) ? 6'h01 << (r - 3'h1) : 6'h00};
  endfunction
  task automatic check_outs;
    logic [2:0] c;
    c = mreg[2][2:0];
    chk({ref_supply, ref_shared, ref_dedicated, ref_internal}, 32'h1 << mreg[2][7:6]);
    chk({reject_60hz, reject_50hz}, fx[mreg[2][5:4]]);
    chk(filter_rate_mismatch, mreg[2][5:4] != 0 && !(sample_rate_code == 0 && op_mode < 2));
    chk(current_level_ua, ua[c]);
    chk({current_code_reserved, current_enable}, {c == 3'h1, c > 3'h1});
    chk({first_route_reserved, first_source_pins}, pins(mreg[3][7:5], c));
    chk({second_route_reserved, second_source_pins}, pins(mreg[3][4:2], c));
  endtask
  task automatic rd_chk(input logic [1:0] a);
    host.rd(a, d);
    chk(reg_rvalid, 1);
    chk(d, a[1] ? mreg[a] : 8'h00);
  endtask
  task automatic pulse(input logic [1:0] k);
    @(posedge core_clk);
    #1;
    {sleep_cmd, start_cmd} = k;
    @(posedge core_clk);
    #1;
    sleep_cmd = 0;
    start_cmd = 0;
  endtask
  task automatic do_reset;
    live = 0;
    rst_n = 0;
    mreg = '{default: 8'h00};
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1;
    check_outs;
    chk({low_side_switch_closed, ready_pin_n, serial_out_ready_pin}, 3'h3);
    for (int i = 0; i < 4; i++) rd_chk(i[1:0]);
    live = 1;
  endtask
  // free-running ready-pin traffic with both pins compared every cycle while live is set
  always @(posedge core_clk)
  begin
    #1;
    if (live) chk(ready_pin_n, !dr_q);
    pq = {dr_q, serial_busy, serial_dout};
    dr_q = 1'($random(seed));
    data_ready = dr_q;
    serial_busy = 1'($random(seed));
    serial_dout = 1'($random(seed));
    // mode model settles after the host task returns in the same step
    #1;
    if (live) chk(serial_out_ready_pin, (mreg[3][1] && !pq[1]) ? !pq[2] : pq[0]);
  end
  initial
  begin
    do_reset;
    repeat (80)
    begin
      op_mode = 2'($random(seed));
      sample_rate_code = ($random(seed) & 1) ? 3'h0 : 3'($random(seed));
      host.wr(2'($random(seed)), 8'($random(seed)), s);
      if (reg_addr[1]) mreg[reg_addr] = s;
      check_outs;
      rd_chk(2'($random(seed)));
    end
    op_mode = 0;
    host.wr(2'h2, 8'h08, s);
    mreg[2] = s;
    pulse(2'h2);
    chk(low_side_switch_closed, 1);
    pulse(2'h1);
    chk(low_side_switch_closed, 0);
    pulse(2'h2);
    pulse(2'h3);
    chk(low_side_switch_closed, 0);
    pulse(2'h2);
    host.wr(2'h2, 8'h00, s);
    mreg[2] = s;
    @(posedge core_clk);
    #1;
    chk(low_side_switch_closed, 0);
    pulse(2'h2);
    chk(low_side_switch_closed, 0);
    host.wr(2'h3, 8'hff, s);
    do_reset;
    final_report;
  end
  initial
  begin
    #(5000 * 50);
    errors++;
    final_report;
  end
endmodule

// File: dv/arec_config_sva.sv
// port assertions for the reference / excitation config block
// assumes a bind onto arec_config; one clock domain
module arec_config_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [arec_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [arec_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [arec_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic start_cmd,
  input wire logic sleep_cmd,
  input wire logic data_ready,
  input wire logic serial_busy,
  input wire logic serial_dout,
  input wire logic ref_internal,
  input wire logic ref_dedicated,
  input wire logic ref_shared,
  input wire logic ref_supply,
  input wire logic reject_50hz,
  input wire logic reject_60hz,
  input wire logic low_side_switch_closed,
  input wire logic current_enable,
  input wire logic current_code_reserved,
  input wire logic [arec_pkg::ROUTE_PINS-1:0] first_source_pins,
  input wire logic first_route_reserved,
  input wire logic ready_pin_n,
  input wire logic serial_out_ready_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // shadow copies of the two control bits the ports cannot show
  logic sw_en;
  logic rdy_mode;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n) sw_en <= 1'b0;
    else if (reg_wr && reg_addr == 2'h2) sw_en <= reg_wdata[3];
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n) rdy_mode <= 1'b0;
    else if (reg_wr && reg_addr == 2'h3) rdy_mode <= reg_wdata[1];
  end
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_unmapped_read: assert property (reg_rd && !reg_addr[1] |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ref_onehot: assert property ($onehot({ref_internal, ref_dedicated, ref_shared, ref_supply}))
    else $error("reference select not one-hot");
  a_filter_decode: assert property (reg_wr && reg_addr == 2'h2 |=>
    reject_50hz == ($past(reg_wdata[5:4]) inside {2'h1, 2'h2})
    && reject_60hz == ($past(reg_wdata[5:4]) inside {2'h1, 2'h3})) else $error("filter decode");
  a_current_decode: assert property (reg_wr && reg_addr == 2'h2 |=>
    current_enable == ($past(reg_wdata[2:1]) != 2'h0)
    && current_code_reserved == ($past(reg_wdata[2:0]) == 3'h1)) else $error("current decode");
  a_pins_gated: assert property (first_source_pins != 6'h00 |-> current_enable
    && !first_route_reserved && $onehot(first_source_pins)) else $error("bad first route");
  a_switch_forced: assert property (reg_wr && reg_addr == 2'h2 && !reg_wdata[3] |=>
    ##1 !low_side_switch_closed) else $error("switch not forced open");
  a_sleep_close: assert property (sleep_cmd && !start_cmd && sw_en |=> low_side_switch_closed)
    else $error("sleep did not close switch");
  a_start_open: assert property (start_cmd |=> !low_side_switch_closed)
    else $error("start did not open switch");
  a_ready_pin: assert property ($past(rst_n) |-> ready_pin_n == !$past(data_ready))
    else $error("ready pin wrong");
  a_serial_pin: assert property ($past(rst_n) |-> serial_out_ready_pin ==
    ((rdy_mode && !$past(serial_busy)) ? !$past(data_ready) : $past(serial_dout)))
    else $error("shared pin wrong");
  cover property (reg_rvalid && reg_rdata != 8'h00);
  cover property ($rose(low_side_switch_closed));
  cover property (rdy_mode && !serial_busy && data_ready);
endmodule

bind arec_config arec_config_sva u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .start_cmd(start_cmd), .sleep_cmd(sleep_cmd), .data_ready(data_ready),
  .serial_busy(serial_busy), .serial_dout(serial_dout), .ref_internal(ref_internal),
  .ref_dedicated(ref_dedicated), .ref_shared(ref_shared), .ref_supply(ref_supply),
  .reject_50hz(reject_50hz), .reject_60hz(reject_60hz),
  .low_side_switch_closed(low_side_switch_closed), .current_enable(current_enable),
  .current_code_reserved(current_code_reserved), .first_source_pins(first_source_pins),
  .first_route_reserved(first_route_reserved), .ready_pin_n(ready_pin_n),
  .serial_out_ready_pin(serial_out_ready_pin)
);

// File: dv/arec_host_model.sv
// host side of the register strobe port
// assumes the bench calls its tasks; strobes move 1 ns after the rising edge
module arec_host_model (
  input wire logic core_clk,
  input wire logic [arec_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [1:0] op_mode,
  input wire logic [2:0] sample_rate_code,
  output logic reg_wr,
  output logic reg_rd,
  output logic [arec_pkg::REG_ADDR_W-1:0] reg_addr,
  output logic [arec_pkg::DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d, output logic [7:0] sent);
    @(posedge core_clk);
    #1;
    if (a == 2'h3) d[0] = 1'b0;
    // filter stays off outside the slowest normal or duty-cycle rate
    if (!(sample_rate_code == 3'h0 && op_mode <= 2'h1)) d[5:4] = 2'h0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    sent = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// File: shared/arec_pkg.sv
// constants, encodings and decode helpers for the reference / excitation config block
// assumes a 2-bit register index from the command decoder; indices 0 and 1 live elsewhere
package arec_pkg;

  localparam int REG_ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int CUR_UA_W = 11;
  localparam int ROUTE_PINS = 6;
  localparam int REF_KINDS = 4;

  // register indices on the command decoder's index bus
  localparam logic [REG_ADDR_W-1:0] REF_FILT_EXC_ADDR = 2'h2;
  localparam logic [REG_ADDR_W-1:0] ROUTE_READY_ADDR = 2'h3;

  localparam logic [DATA_W-1:0] REF_FILT_EXC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ROUTE_READY_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // reference_filter_excitation_config fields
  localparam int REF_SEL_HI = 7;
  localparam int REF_SEL_LO = 6;
  localparam int FILT_HI = 5;
  localparam int FILT_LO = 4;
  localparam int SWITCH_BIT = 3;
  localparam int CUR_HI = 2;
  localparam int CUR_LO = 0;

  // excitation_routing_ready_config fields
  localparam int ROUTE1_HI = 7;
  localparam int ROUTE1_LO = 5;
  localparam int ROUTE2_HI = 4;
  localparam int ROUTE2_LO = 2;
  localparam int READY_MODE_BIT = 1;
  localparam int SPARE_BIT = 0;

  typedef enum logic [1:0] {
    AREC_REF_INTERNAL = 2'h0,
    AREC_REF_DEDICATED = 2'h1,
    AREC_REF_SHARED = 2'h2,
    AREC_REF_SUPPLY = 2'h3
  } arec_ref_e;

  typedef enum logic [1:0] {
    AREC_FILT_NONE = 2'h0,
    AREC_FILT_BOTH = 2'h1,
    AREC_FILT_50 = 2'h2,
    AREC_FILT_60 = 2'h3
  } arec_filt_e;

  localparam logic [2:0] CUR_OFF = 3'h0;
  localparam logic [2:0] CUR_RESERVED = 3'h1;
  // magnitude in microamps, indexed by the current code
  localparam logic [CUR_UA_W-1:0] CUR_UA_TABLE [8] = '{
    11'h000, 11'h000, 11'h032, 11'h064, 11'h0fa, 11'h1f4, 11'h3e8, 11'h5dc
  };

  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [2:0] ROUTE_RESERVED = 3'h7;
  // one-hot pin order: shared_ref_pos_input, analog_input_one, analog_input_two,
  // shared_ref_neg_input, dedicated_ref_pos, dedicated_ref_neg (bit 0 first)

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DUTY = 2'h1;
  localparam logic [2:0] RATE_SLOWEST = 3'h0;

  function automatic logic [ROUTE_PINS-1:0] arec_route_onehot(input logic [2:0] code);
    logic [ROUTE_PINS-1:0] pins;
    pins = '0;
    if (code != ROUTE_OFF && code != ROUTE_RESERVED)
    begin
      pins[code - 3'h1] = 1'b1;
    end
    return pins;
  endfunction

endpackage
